// ==== apfm_params.svh ====
// Constants of the amplifier protection and fault monitor.
// Assumes a 100 MHz system clock and analog detectors outside.
`ifndef APFM_PARAMS_SVH
`define APFM_PARAMS_SVH
`define APFM_SYS_MHZ        100
`define APFM_SC_SHUT_US     200
`define APFM_SC_SHUT_CYC    (`APFM_SC_SHUT_US * `APFM_SYS_MHZ)
`define APFM_WARN1_C        8'h7d
`define APFM_WARN2_C        8'h87
`define APFM_WARN3_C        8'h91
`define APFM_HYST_C         8'h0a
`define APFM_SHUT_C         8'h9b
`define APFM_SHUT_REL_C     8'h91
`define APFM_ADDR_BASE      7'h6c
`define APFM_TEMP_LSB       5
`define APFM_FAULT_REG_LAST 8'h01
`define APFM_STRAP_WAIT     2'h3
`endif

// ==== apfm_pkg.sv ====
// Types of the amplifier protection and fault monitor.
// Assumes the constants header is on the include path.
`include "apfm_params.svh"
package apfm_pkg;
  typedef enum logic [1:0] {
    APFM_G12 = 2'b00,
    APFM_G20 = 2'b01,
    APFM_G26 = 2'b10,
    APFM_G32 = 2'b11
  } apfm_gain_e;

  typedef enum logic [1:0] {
    APFM_FL_HEAT  = 2'b00,
    APFM_FL_CLIP  = 2'b01,
    APFM_FL_BOTH  = 2'b10,
    APFM_FL_TWEET = 2'b11
  } apfm_flag_e;

  typedef struct packed {
    logic por;
    logic load_dump;
    logic psup_high;
    logic gpump_low;
    logic asup_low;
    logic psup_low;
  } apfm_supply_s;

  typedef struct packed {
    logic         osc_align;
    logic [3:0]   avg_over;
    logic [3:0]   peak_over;
    logic [3:0]   full_duty;
    logic [3:0]   tweeter;
    apfm_supply_s sup;
    logic [1:0]   strap;
  } apfm_pins_s;

  typedef struct packed {
    logic       heat_shut;
    logic       load_dump;
    logic       psup_high;
    logic       gpump_low;
    logic       asup_low;
    logic       psup_low;
    logic [3:0] dc;
    logic [3:0] sc;
  } apfm_fault_s;

  typedef struct packed {
    apfm_pins_s            s1;
    apfm_pins_s            s2;
    logic                  osc_prev;
    logic [3:0]            cut;
    logic [3:0][14:0]      sc_cnt;
    logic [3:0][15:0]      dc_cnt;
    logic [2:0]            warn;
    logic                  heat_shut;
    logic [3:0]            run;
    apfm_fault_s           flt;
    apfm_flag_e            flag_sel;
    apfm_gain_e [3:0]      gain;
    logic [1:0]            strap_cnt;
    logic [1:0]            strap;
  } apfm_state_s;
endpackage : apfm_pkg

// ==== apfm_monitor.sv ====
// Protection and fault monitor of a four-channel class-D amplifier.
// Assumes analog comparators on pins, bus engine drives the strobes.
`include "apfm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module apfm_monitor #(
  parameter int unsigned SC_SHUT_CYC = `APFM_SC_SHUT_CYC
) (
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_NRST,
  input  wire logic                  I_OSC_ALIGN,
  input  wire logic [3:0]            I_AVG_OVER,
  input  wire logic [3:0]            I_PEAK_OVER,
  input  wire logic [3:0]            I_FULL_DUTY,
  input  wire logic [3:0]            I_TWEETER,
  input  wire apfm_pkg::apfm_supply_s I_SUPPLY,
  input  wire logic [1:0]            I_ADDR_STRAP,
  input  wire logic [31:0]           I_DC_LEVEL,
  input  wire logic [7:0]            I_DC_POS_THR,
  input  wire logic [7:0]            I_DC_NEG_THR,
  input  wire logic [15:0]           I_DC_TIME,
  input  wire logic                  I_DC_SHUT_EN,
  input  wire logic [7:0]            I_TEMP_C,
  input  wire logic [3:0]            I_MUTE,
  input  wire logic [3:0]            I_UNMUTE,
  input  wire logic [3:0]            I_GAIN_WR,
  input  wire logic [1:0]            I_GAIN_VAL,
  input  wire logic                  I_FLAG_WR,
  input  wire logic [1:0]            I_FLAG_SEL,
  input  wire logic [7:0]            I_SUB_ADDR,
  output logic [3:0]                 O_PULSE_CUT,
  output logic [3:0]                 O_PEAK_LIMIT,
  output logic [3:0]                 O_CH_PLAY,
  output logic [3:0]                 O_FAST_HIZ,
  output logic [7:0]                 O_GAIN,
  output logic [7:0]                 O_FAULT0,
  output logic [7:0]                 O_FAULT1,
  output logic [7:0]                 O_TEMP_REG,
  output logic                       O_ERR_ALERT_O,
  output logic                       O_ERR_ALERT_OE,
  output logic                       O_CLIP_HEAT_O,
  output logic                       O_CLIP_HEAT_OE,
  output logic                       O_BUS_RELEASE,
  output logic [6:0]                 O_BUS_ADDR,
  output logic                       O_OSC_MASTER,
  output logic                       O_AUTOINC_OK
);

  apfm_pkg::apfm_state_s q;
  apfm_pkg::apfm_state_s d;
  apfm_pkg::apfm_pins_s  pins;

  logic       osc_edge;
  logic       por;
  logic       global_stop;
  logic       clip_any;
  logic       tweet_any;
  logic       flag_on;
  logic [3:0] dc_over;
  logic [3:0] stop_fault;

  // Hysteresis comparator on die temperature
  function automatic logic hyst(input logic cur, input logic [7:0] t,
                                input logic [7:0] set_c, input logic [7:0] rel_c);
    logic r;
    r = cur;
    if (t >= set_c) begin
      r = 1'b1;
    end else if (t < rel_c) begin
      r = 1'b0;
    end
    return r;
  endfunction : hyst

  // Signed byte against positive and negative thresholds
  function automatic logic dc_cmp(input logic [7:0] lvl, input logic [7:0] pos,
                                  input logic [7:0] neg);
    logic signed [8:0] l;
    logic signed [8:0] p;
    logic signed [8:0] n;
    l = $signed({lvl[7], lvl});
    p = $signed({1'b0, pos});
    n = -$signed({1'b0, neg});
    return (l >= p) || (l <= n);
  endfunction : dc_cmp

  always_comb begin
    pins.osc_align = I_OSC_ALIGN;
    pins.avg_over  = I_AVG_OVER;
    pins.peak_over = I_PEAK_OVER;
    pins.full_duty = I_FULL_DUTY;
    pins.tweeter   = I_TWEETER;
    pins.sup       = I_SUPPLY;
    pins.strap     = I_ADDR_STRAP;
  end

  assign osc_edge = q.s2.osc_align & ~q.osc_prev;
  assign por      = q.s2.sup.por;

  always_comb begin
    d          = q;
    d.s1       = pins;
    d.s2       = q.s1;
    d.osc_prev = q.s2.osc_align;

    if (q.strap_cnt != `APFM_STRAP_WAIT) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      d.strap     = q.s2.strap;
    end

    d.warn[0] = hyst(q.warn[0], I_TEMP_C, `APFM_WARN1_C,
                     8'(`APFM_WARN1_C - `APFM_HYST_C));
    d.warn[1] = hyst(q.warn[1], I_TEMP_C, `APFM_WARN2_C,
                     8'(`APFM_WARN2_C - `APFM_HYST_C));
    d.warn[2] = hyst(q.warn[2], I_TEMP_C, `APFM_WARN3_C,
                     8'(`APFM_WARN3_C - `APFM_HYST_C));
    d.heat_shut = hyst(q.heat_shut, I_TEMP_C, `APFM_SHUT_C, `APFM_SHUT_REL_C);

    for (int c = 0; c < 4; c++) begin
      if (I_MUTE[c]) begin
        d.run[c] = 1'b0;
      end else if (I_UNMUTE[c]) begin
        d.run[c] = 1'b1;
      end
    end

    if (|I_UNMUTE) begin
      d.flt.heat_shut = 1'b0;
      d.flt.load_dump = 1'b0;
      d.flt.psup_high = 1'b0;
      d.flt.gpump_low = 1'b0;
      d.flt.asup_low  = 1'b0;
      d.flt.psup_low  = 1'b0;
      d.flt.sc        = q.flt.sc & ~I_UNMUTE;
      d.flt.dc        = q.flt.dc & ~I_UNMUTE;
    end

    for (int c = 0; c < 4; c++) begin
      if (q.s2.avg_over[c]) begin
        d.cut[c] = 1'b1;
      end else if (osc_edge) begin
        d.cut[c] = 1'b0;
      end

      // peak held long enough stops channel
      if (q.s2.peak_over[c] && q.run[c]) begin
        d.sc_cnt[c] = q.sc_cnt[c] + 15'h1;
        if (q.sc_cnt[c] == 15'(SC_SHUT_CYC - 1)) begin
          d.sc_cnt[c] = '0;
          d.flt.sc[c] = 1'b1;
          d.run[c]    = 1'b0;
        end
      end else begin
        d.sc_cnt[c] = '0;
      end

      if (dc_over[c] && q.run[c]) begin
        if (q.dc_cnt[c] >= I_DC_TIME) begin
          d.flt.dc[c] = 1'b1;
          if (I_DC_SHUT_EN) begin
            d.run[c] = 1'b0;
          end
        end else begin
          d.dc_cnt[c] = q.dc_cnt[c] + 16'h1;
        end
      end else begin
        d.dc_cnt[c] = '0;
      end

      if (I_GAIN_WR[c]) begin
        d.gain[c] = apfm_pkg::apfm_gain_e'(I_GAIN_VAL);
      end
    end

    if (q.s2.sup.psup_low) begin
      d.flt.psup_low = 1'b1;
    end
    if (q.s2.sup.asup_low) begin
      d.flt.asup_low = 1'b1;
    end
    if (q.s2.sup.gpump_low) begin
      d.flt.gpump_low = 1'b1;
    end
    if (q.s2.sup.psup_high) begin
      d.flt.psup_high = 1'b1;
    end
    if (q.s2.sup.load_dump) begin
      d.flt.load_dump = 1'b1;
    end
    if (q.heat_shut) begin
      d.flt.heat_shut = 1'b1;
    end
    // global fault stops all at once
    if (global_stop) begin
      d.run = 4'h0;
    end

    if (I_FLAG_WR) begin
      d.flag_sel = apfm_pkg::apfm_flag_e'(I_FLAG_SEL);
    end

    if (por) begin
      d.run      = 4'h0;
      d.flt      = '0;
      for (int c = 0; c < 4; c++) begin
        d.gain[c] = apfm_pkg::APFM_G12;
      end
      d.flag_sel = apfm_pkg::APFM_FL_HEAT;
      d.cut      = 4'h0;
      d.sc_cnt   = '0;
      d.dc_cnt   = '0;
    end
  end

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      dc_over[c] = dc_cmp(I_DC_LEVEL[8*c +: 8], I_DC_POS_THR, I_DC_NEG_THR);
    end
  end

  assign global_stop = q.heat_shut | q.s2.sup.load_dump | q.s2.sup.psup_low |
                       q.s2.sup.asup_low | q.s2.sup.gpump_low | q.s2.sup.psup_high;

  assign stop_fault = q.flt.sc | (q.flt.dc & {4{I_DC_SHUT_EN}}) | {4{global_stop}};

  assign clip_any  = |q.s2.full_duty;
  assign tweet_any = |q.s2.tweeter;

  always_comb begin
    case (q.flag_sel)
      // heat warning is the reset code
      apfm_pkg::APFM_FL_HEAT:  flag_on = q.warn[0];
      apfm_pkg::APFM_FL_CLIP:  flag_on = clip_any;
      apfm_pkg::APFM_FL_BOTH:  flag_on = clip_any | q.warn[0];
      apfm_pkg::APFM_FL_TWEET: flag_on = tweet_any;
      default:                 flag_on = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign O_PULSE_CUT  = q.cut;
  assign O_PEAK_LIMIT = q.s2.peak_over & q.run;
  assign O_CH_PLAY    = q.run;
  assign O_FAST_HIZ   = stop_fault;
  assign O_GAIN       = q.gain;
  assign O_FAULT0     = {2'h0, q.flt.heat_shut, q.flt.load_dump, q.flt.psup_high,
                         q.flt.gpump_low, q.flt.asup_low, q.flt.psup_low};
  assign O_FAULT1     = {q.flt.dc, q.flt.sc};
  assign O_TEMP_REG   = {q.warn, 5'h00};

  assign O_ERR_ALERT_O  = 1'b0;
  assign O_ERR_ALERT_OE = |q.flt;
  assign O_CLIP_HEAT_O  = 1'b0;
  assign O_CLIP_HEAT_OE = flag_on;

  assign O_BUS_RELEASE = por;
  assign O_BUS_ADDR    = `APFM_ADDR_BASE + {5'h00, q.strap};
  assign O_OSC_MASTER  = (q.strap == 2'h0);

  assign O_AUTOINC_OK  = (I_SUB_ADDR > `APFM_FAULT_REG_LAST);

endmodule : apfm_monitor
`default_nettype wire

// ==== apfm_monitor_end.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== apfm_monitor_props.sv ====
// Port checks of the fault monitor.
// Assumes bind onto apfm_monitor; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module apfm_props (
  input wire logic       I_SYS_CLK,
  input wire logic       I_NRST,
  input wire logic [7:0] I_SUB_ADDR,
  input wire logic [3:0] I_MUTE,
  input wire logic [3:0] I_PEAK_OVER,
  input wire logic [3:0] I_GAIN_WR,
  input wire logic [1:0] I_GAIN_VAL,
  input wire logic [3:0] O_CH_PLAY,
  input wire logic [3:0] O_PEAK_LIMIT,
  input wire logic [7:0] O_GAIN,
  input wire logic [7:0] O_FAULT0,
  input wire logic [7:0] O_FAULT1,
  input wire logic       O_ERR_ALERT_OE,
  input wire logic       O_BUS_RELEASE,
  input wire logic [6:0] O_BUS_ADDR,
  input wire logic       O_OSC_MASTER,
  input wire logic       O_AUTOINC_OK
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  a_alert_on_fault: assert property (O_ERR_ALERT_OE ==
    ((|O_FAULT0) || (|O_FAULT1)))
    else $error("alert missing");
  a_short_stops: assert property ($rose(O_FAULT1[0]) |-> ##[0:1] !O_CH_PLAY[0])
    else $error("shorted channel plays");
  a_heat_stops_all: assert property (O_FAULT0[5] |-> ##[0:1] (O_CH_PLAY == 4'h0))
    else $error("plays in heat stop");
  a_peak_recovers: assert property ((!I_PEAK_OVER[0]) [*3] |-> !O_PEAK_LIMIT[0])
    else $error("peak limit stuck");
  a_addr_map: assert property ((O_BUS_ADDR[6:2] == 5'h1b)
    && (O_OSC_MASTER == (O_BUS_ADDR[1:0] == 2'h0)))
    else $error("bad address");
  a_autoinc_map: assert property (O_AUTOINC_OK == (I_SUB_ADDR > 8'h01))
    else $error("bad autoinc");
  a_gain_write: assert property (I_GAIN_WR[0] && !O_BUS_RELEASE
    |=> (O_GAIN[1:0] == $past(I_GAIN_VAL)))
    else $error("gain not taken");
  a_mute_stops: assert property (I_MUTE[2] |=> !O_CH_PLAY[2])
    else $error("mute ignored");
endmodule : apfm_props
bind apfm_monitor apfm_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
  .I_SUB_ADDR(I_SUB_ADDR), .I_MUTE(I_MUTE), .I_GAIN_WR(I_GAIN_WR), .I_GAIN_VAL(I_GAIN_VAL),
  .I_PEAK_OVER(I_PEAK_OVER), .O_GAIN(O_GAIN),
  .O_CH_PLAY(O_CH_PLAY), .O_PEAK_LIMIT(O_PEAK_LIMIT), .O_FAULT0(O_FAULT0),
  .O_FAULT1(O_FAULT1), .O_ERR_ALERT_OE(O_ERR_ALERT_OE), .O_BUS_RELEASE(O_BUS_RELEASE),
  .O_BUS_ADDR(O_BUS_ADDR), .O_OSC_MASTER(O_OSC_MASTER), .O_AUTOINC_OK(O_AUTOINC_OK));
`default_nettype wire

// ==== apfm_host_model.sv ====
// Host model: command strobes and free-running oscillator mark.
// Assumes the bench clock on i_clk; strobes move 1 ns after its edge.
`timescale 1ns/10ps
`default_nettype none
module apfm_host_model (
  input  wire logic  i_clk,
  output logic       o_osc,
  output logic [3:0] o_mute,
  output logic [3:0] o_unmute,
  output logic [3:0] o_gain_wr,
  output logic [1:0] o_val,
  output logic       o_flag_wr
);
  initial begin
    {o_osc, o_mute, o_unmute, o_gain_wr, o_val, o_flag_wr} = '0;
  end
  always #62.5 o_osc = ~o_osc;
  task automatic cmd(input logic [3:0] m, u, g, input logic [1:0] v, input logic f);
    @(posedge i_clk);
    #1 {o_mute, o_unmute, o_gain_wr, o_val, o_flag_wr} = {m, u, g, v, f};
    @(posedge i_clk);
    #1 {o_mute, o_unmute, o_gain_wr, o_flag_wr} = '0;
  endtask : cmd
  task automatic reinit();
    cmd(4'h0, 4'hf, 4'h0, 2'h0, 1'b0);
  endtask : reinit
endmodule : apfm_host_model
`default_nettype wire

// ==== apfm_monitor_tb.sv ====
// Bench: host command sequences with expected port values.
// Assumes host model and bound checker compile beside the design.
`timescale 1ns/10ps
`default_nettype none
module apfm_monitor_tb;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic [3:0]             avg = 4'h0, peak = 4'h0, full = 4'h0, tweet = 4'h0;
  apfm_pkg::apfm_supply_s sup = 6'h00;
  logic [31:0]            dcl = 32'h0;
  logic                   dc_en = 1'b0;
  logic [7:0]             temp = 8'h19, sub = 8'h00;
  logic                   osc, fwr, alrt, flag, rel, mst, ainc;
  logic [3:0]             mute, unmute, gwr, cut, plim, play, hiz;
  logic [1:0]             gval;
  logic [7:0]             gain, f0, f1, treg;
  logic [6:0]             addr;
  int                     mismatches = 0, cmp_count = 0, cycles = 0;
  always #5 clk = ~clk;
  apfm_host_model host (.i_clk(clk), .o_osc(osc), .o_mute(mute), .o_unmute(unmute),
    .o_gain_wr(gwr), .o_val(gval), .o_flag_wr(fwr));
  apfm_monitor #(.SC_SHUT_CYC(20)) dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_OSC_ALIGN(osc),
    .I_AVG_OVER(avg), .I_PEAK_OVER(peak), .I_FULL_DUTY(full), .I_TWEETER(tweet),
    .I_SUPPLY(sup), .I_ADDR_STRAP(2'h2), .I_DC_LEVEL(dcl), .I_DC_POS_THR(8'h20),
    .I_DC_NEG_THR(8'h10), .I_DC_TIME(16'h0004), .I_DC_SHUT_EN(dc_en), .I_TEMP_C(temp),
    .I_MUTE(mute), .I_UNMUTE(unmute), .I_GAIN_WR(gwr), .I_GAIN_VAL(gval), .I_FLAG_WR(fwr),
    .I_FLAG_SEL(gval), .I_SUB_ADDR(sub), .O_PULSE_CUT(cut), .O_PEAK_LIMIT(plim),
    .O_CH_PLAY(play), .O_FAST_HIZ(hiz), .O_GAIN(gain), .O_FAULT0(f0), .O_FAULT1(f1),
    .O_TEMP_REG(treg), .O_ERR_ALERT_O(), .O_ERR_ALERT_OE(alrt), .O_CLIP_HEAT_O(),
    .O_CLIP_HEAT_OE(flag), .O_BUS_RELEASE(rel), .O_BUS_ADDR(addr), .O_OSC_MASTER(mst),
    .O_AUTOINC_OK(ainc));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    cyc(4);
    chk({addr, mst, gain}, 16'hdc00);
    host.reinit();
    chk(play, 16'h000f);
    for (int g = 0; g < 4; g++) host.cmd(4'h0, 4'h0, 4'h1 << g, 2'(g), 1'b0);
    chk(gain, 16'h00e4);
    host.cmd(4'h4, 4'h4, 4'h0, 2'h0, 1'b0);
    chk(play, 16'h000b);
    host.reinit();
    avg = 4'h2;
    cyc(30);
    chk({cut, play}, 16'h002f);
    avg = 4'h0;
    cyc(40);
    chk(cut, 16'h0000);
    peak = 4'h1;
    cyc(5);
    chk(plim, 16'h0001);
    peak = 4'h0;
    cyc(5);
    chk({plim, f1}, 16'h0000);
    peak = 4'h1;
    cyc(12);
    chk(f1, 16'h0000);
    cyc(25);
    chk({alrt, f1, play}, 16'h101e);
    peak = 4'h0;
    host.cmd(4'h0, 4'h1, 4'h0, 2'h0, 1'b0);
    cyc(2);
    chk({alrt, f1, play}, 16'h000f);
    dcl = 32'h0020_0000;
    cyc(10);
    chk({f1, play}, 16'h040f);
    dcl = 32'h0;
    host.cmd(4'h0, 4'h4, 4'h0, 2'h0, 1'b0);
    dc_en = 1'b1;
    dcl = 32'hf000_f100;
    cyc(10);
    chk({alrt, f1, hiz, play}, 32'h0001_8087);
    dcl = 32'h0;
    dc_en = 1'b0;
    host.cmd(4'h0, 4'h8, 4'h0, 2'h0, 1'b0);
    temp = 8'd125;
    cyc(3);
    chk({flag, treg}, 16'h0120);
    temp = 8'd116;
    cyc(3);
    chk({flag, treg}, 16'h0120);
    temp = 8'd114;
    cyc(3);
    chk({flag, treg}, 16'h0000);
    temp = 8'd155;
    cyc(3);
    chk({alrt, f0, play}, 16'h1200);
    chk(treg, 16'h00e0);
    temp = 8'd144;
    cyc(3);
    host.reinit();
    chk({f0, play}, 16'h000f);
    temp = 8'd25;
    full = 4'h4;
    tweet = 4'h8;
    for (int s = 0; s < 4; s++) begin
      sub = 8'(s);
      host.cmd(4'h0, 4'h0, 4'h0, 2'(s), 1'b1);
      cyc(3);
      chk({flag, ainc}, {(s != 0), (s > 1)});
    end
    host.cmd(4'h0, 4'h0, 4'h0, 2'h1, 1'b1);
    full = 4'h0;
    tweet = 4'h0;
    cyc(4);
    chk(flag, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      sup = 6'(1 << i);
      cyc(4);
      chk({alrt, f0, play}, 16'h1000 | 16'(1 << (i + 4)));
      sup = 6'h00;
      cyc(4);
      host.reinit();
      chk({f0, play}, 16'h000f);
    end
    sup = 6'h20;
    cyc(4);
    chk({rel, gain, play}, 16'h1000);
    sup = 6'h00;
    cyc(4);
    host.reinit();
    chk({rel, play}, 16'h000f);
    summarize();
  end
endmodule : apfm_monitor_tb
`default_nettype wire
